// ===== hw/rfli_top.sv
// Purpose: Receive alarm-code validation/removal and data-link message
//          events, with status, enables and an active-low request pin.
// Assumes: Partner inputs are synchronous to aclk; one strobe per reception.
// Notes:   Registers sit on an AXI4-Lite slave; status bits clear on read.
//          History survives validation and removal, so a new code must wait
//          for the old one to be removed before it can be validated.
//          Message bytes and completion are dropped while the receiver is off.
//
// Overview of operation
// - Read-only alarm-code register holds the present validated six-bit code, else zero; upper bits zero.
// - Removal of the validated code raises an interrupt when removal is enabled.
// - Validated code is removed once 3 of last 10 receptions differ from it.
// - Bit 3 of the alarm-code control register enables the removal interrupt.
// - Any enabled event drives the interrupt request output low.
// - Removal sets the removal status flag, bit 2 of alarm-code control.
// - Removal clears the validated code from the alarm-code register.
// - A completed stored data-link message interrupts when that interrupt is enabled.
// - Bit 1 of the data-link control register enables the message interrupt.
// - Message completion sets the message status flag, bit 0 of data-link control.
// - Received message bytes are written into the buffer at indices 0xde to 0x135.
// - A code is validated once it arrives in 8 of the last 10 receptions.
// - Bit 1 of the alarm-code control register enables the validation interrupt.
// - Validation sets the validation status flag, bit 0 of alarm-code control.
// - Validation loads the new six-bit code into the alarm-code register.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns

module rfli_top
   import rfli_pkg::*;
(
   input wire logic aclk, // System clock, 100 MHz
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire rfli_code_rx_type code_rx, // Alarm-code receptions
   input wire rfli_msg_rx_type msg_rx, // Data-link message bytes
   output logic rx_datalink_en, // Data-link receiver enable
   output logic irq_n // Interrupt request, active low
);

   typedef struct packed {
      rfli_wr_state_type wr_state;
      logic awready;
      logic aw_got;
      logic [IDX_W-1:0] aw_idx;
      logic wready;
      logic w_got;
      logic [BYTE_W-1:0] wbyte;
      logic wlane;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [HIST_LEN-1:0][CODE_W:0] hist;
      logic code_present;
      logic [CODE_W-1:0] rx_alarm_code_value;
      logic code_valid_irq_en;
      logic code_valid_irq_flag;
      logic code_removal_irq_en;
      logic code_removal_irq_flag;
      logic rx_datalink_en;
      logic rx_msg_irq_en;
      logic rx_msg_irq_flag;
      logic irq_n;
      logic [BUF_DEPTH-1:0][BYTE_W-1:0] msg_mem;
   } rfli_state_type;

   rfli_state_type s;
   rfli_state_type next_s;

   // History as it stands once the current reception is shifted in
   logic [HIST_LEN-1:0][CODE_W:0] hist_new;
   logic [HIST_LEN-1:0] same_new;
   logic [HIST_LEN-1:0] diff_held;
   logic [CNT_W-1:0] same_cnt;
   logic [CNT_W-1:0] diff_cnt;
   logic validate_ev;
   logic remove_ev;
   logic [BUF_DEPTH-1:0] buf_wr_hit;

   assign hist_new = code_rx.strobe ?
      {s.hist[HIST_LEN-2:0], {1'b1, code_rx.code}} : s.hist;

   // Empty history slots carry a clear valid bit and never count
   genvar gi;
   generate
      for (gi = 0; gi < HIST_LEN; gi++) begin : g_hist
         assign same_new[gi] = hist_new[gi][CODE_W] &&
            (hist_new[gi][CODE_W-1:0] == code_rx.code);
         assign diff_held[gi] = hist_new[gi][CODE_W] &&
            (hist_new[gi][CODE_W-1:0] != s.rx_alarm_code_value);
      end
   endgenerate

   assign same_cnt = CNT_W'($countones(same_new));
   assign diff_cnt = CNT_W'($countones(diff_held));

   // One write strobe per buffer entry; addresses past the end match none
   generate
      for (gi = 0; gi < BUF_DEPTH; gi++) begin : g_buf
         assign buf_wr_hit[gi] = msg_rx.wr && s.rx_datalink_en &&
            (msg_rx.addr == BUF_AW'(gi));
      end
   endgenerate

   // Only judged on a reception; the present flag keeps the two exclusive
   assign validate_ev = code_rx.strobe && !s.code_present &&
      (same_cnt >= VALID_HITS);
   assign remove_ev = code_rx.strobe && s.code_present &&
      (diff_cnt >= REMOVE_HITS);

   // Word decode shared by the write and read responses
   function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
      logic hit;
      hit = 1'b0;
      case (idx)
         IDX_ALARM_CODE: begin
            hit = 1'b1;
         end
         IDX_IRQ_CTRL: begin
            hit = 1'b1;
         end
         IDX_DL_CTRL: begin
            hit = 1'b1;
         end
         default: begin
            hit = (idx >= IDX_BUF_FIRST) && (idx <= IDX_BUF_LAST);
         end
      endcase
      return hit;
   endfunction

   always_comb begin
      logic aw_hs;
      logic w_hs;
      logic ar_hs;
      logic [IDX_W-1:0] ridx;
      logic [IDX_W-1:0] boff;
      logic [31:0] rword;
      logic [2:0] irq_src;
      irq_src = '0;
      aw_hs = 1'b0;
      w_hs = 1'b0;
      ar_hs = 1'b0;
      ridx = '0;
      boff = '0;
      rword = '0;
      next_s = s;

      // Write channel: address and data accepted in either order
      aw_hs = s_axi_awvalid && s.awready;
      w_hs = s_axi_wvalid && s.wready;
      if (aw_hs) begin
         next_s.aw_got = 1'b1;
         next_s.aw_idx = s_axi_awaddr[ADDR_W-1:2];
      end
      if (w_hs) begin
         next_s.w_got = 1'b1;
         next_s.wbyte = s_axi_wdata[BYTE_W-1:0];
         next_s.wlane = s_axi_wstrb[0];
      end
      case (s.wr_state)
         WR_COLLECT: begin
            if (next_s.aw_got && next_s.w_got) begin
               next_s.aw_got = 1'b0;
               next_s.w_got = 1'b0;
               next_s.bvalid = 1'b1;
               next_s.wr_state = WR_RESPOND;
               next_s.bresp = is_mapped(next_s.aw_idx) ? RESP_OKAY : RESP_SLVERR;
               // Status, present and code bits are read-only; writes skip them
               if (next_s.wlane) begin
                  case (next_s.aw_idx)
                     IDX_IRQ_CTRL: begin
                        next_s.code_valid_irq_en = next_s.wbyte[BIT_VALID_EN];
                        next_s.code_removal_irq_en = next_s.wbyte[BIT_REMOVE_EN];
                     end
                     IDX_DL_CTRL: begin
                        next_s.rx_msg_irq_en = next_s.wbyte[BIT_MSG_EN];
                        next_s.rx_datalink_en = next_s.wbyte[BIT_DL_EN];
                     end
                     default: begin
                        // Code register and buffer take no writes
                     end
                  endcase
               end
            end
         end
         WR_RESPOND: begin
            if (s_axi_bready) begin
               next_s.bvalid = 1'b0;
               next_s.wr_state = WR_COLLECT;
            end
         end
         default: begin
            next_s.wr_state = WR_COLLECT;
            next_s.bvalid = 1'b0;
         end
      endcase
      next_s.awready = (next_s.wr_state == WR_COLLECT) && !next_s.aw_got;
      next_s.wready = (next_s.wr_state == WR_COLLECT) && !next_s.w_got;

      // Read channel: data is captured at the address handshake
      ar_hs = s_axi_arvalid && s.arready;
      ridx = s_axi_araddr[ADDR_W-1:2];
      boff = ridx - IDX_BUF_FIRST;
      case (ridx)
         IDX_ALARM_CODE: begin
            rword[CODE_W-1:0] = s.rx_alarm_code_value;
         end
         IDX_IRQ_CTRL: begin
            rword[BIT_VALID_FLAG] = s.code_valid_irq_flag;
            rword[BIT_VALID_EN] = s.code_valid_irq_en;
            rword[BIT_REMOVE_FLAG] = s.code_removal_irq_flag;
            rword[BIT_REMOVE_EN] = s.code_removal_irq_en;
            rword[BIT_PRESENT] = s.code_present;
         end
         IDX_DL_CTRL: begin
            rword[BIT_MSG_FLAG] = s.rx_msg_irq_flag;
            rword[BIT_MSG_EN] = s.rx_msg_irq_en;
            rword[BIT_DL_EN] = s.rx_datalink_en;
         end
         default: begin
            // Unmapped words read as zero
            if (ridx >= IDX_BUF_FIRST && ridx <= IDX_BUF_LAST) begin
               rword[BYTE_W-1:0] = s.msg_mem[boff[BUF_AW-1:0]];
            end
         end
      endcase
      if (ar_hs) begin
         next_s.arready = 1'b0;
         next_s.rvalid = 1'b1;
         next_s.rdata = rword;
         next_s.rresp = is_mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
         // Clear-on-read first, so an event in the same cycle survives
         if (ridx == IDX_IRQ_CTRL) begin
            next_s.code_valid_irq_flag = 1'b0;
            next_s.code_removal_irq_flag = 1'b0;
         end
         if (ridx == IDX_DL_CTRL) begin
            next_s.rx_msg_irq_flag = 1'b0;
         end
      end else if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
         next_s.arready = 1'b1;
      end else if (!s.rvalid) begin
         next_s.arready = 1'b1;
      end

      // Alarm-code processor
      if (code_rx.strobe) begin
         next_s.hist = hist_new;
      end
      if (validate_ev) begin
         next_s.code_present = 1'b1;
         next_s.rx_alarm_code_value = code_rx.code;
         next_s.code_valid_irq_flag = 1'b1;
      end
      if (remove_ev) begin
         next_s.code_present = 1'b0;
         next_s.rx_alarm_code_value = RST_CODE;
         next_s.code_removal_irq_flag = 1'b1;
      end

      // Data-link message store; ignored while the receiver is disabled
      for (int k = 0; k < BUF_DEPTH; k++) begin
         if (buf_wr_hit[k]) begin
            next_s.msg_mem[k] = msg_rx.data;
         end
      end
      if (msg_rx.done && s.rx_datalink_en) begin
         next_s.rx_msg_irq_flag = 1'b1;
      end

      // Request follows the next flag state so it moves with the flag
      irq_src[0] = next_s.code_valid_irq_en && next_s.code_valid_irq_flag;
      irq_src[1] = next_s.code_removal_irq_en && next_s.code_removal_irq_flag;
      irq_src[2] = next_s.rx_msg_irq_en && next_s.rx_msg_irq_flag;
      next_s.irq_n = !(|irq_src);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s.wr_state <= WR_COLLECT;
         s.awready <= 1'b0;
         s.aw_got <= 1'b0;
         s.aw_idx <= '0;
         s.wready <= 1'b0;
         s.w_got <= 1'b0;
         s.wbyte <= '0;
         s.wlane <= 1'b0;
         s.bvalid <= 1'b0;
         s.bresp <= RESP_OKAY;
         s.arready <= 1'b0;
         s.rvalid <= 1'b0;
         s.rdata <= '0;
         s.rresp <= RESP_OKAY;
         s.hist <= '0;
         s.code_present <= 1'b0;
         s.rx_alarm_code_value <= RST_CODE;
         s.code_valid_irq_en <= RST_EN;
         s.code_valid_irq_flag <= RST_FLAG;
         s.code_removal_irq_en <= RST_EN;
         s.code_removal_irq_flag <= RST_FLAG;
         s.rx_datalink_en <= RST_EN;
         s.rx_msg_irq_en <= RST_EN;
         s.rx_msg_irq_flag <= RST_FLAG;
         s.irq_n <= 1'b1;
         s.msg_mem <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.arready;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign rx_datalink_en = s.rx_datalink_en;
   assign irq_n = s.irq_n;

endmodule

// ===== hw/rfli_pkg.sv
// Purpose: Shared constants and carrier types of the receive alarm-code
//          and data-link event block.
// Assumes: AXI4-Lite data is 32 bits; register indices are word indices.
// Notes:   Byte address of a register is four times its index.
package rfli_pkg;

   // Bus geometry
   localparam int ADDR_W = 12;
   localparam int IDX_W = ADDR_W - 2;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Register indices as printed
   localparam logic [IDX_W-1:0] IDX_ALARM_CODE = 10'h016;
   localparam logic [IDX_W-1:0] IDX_IRQ_CTRL = 10'h017;
   localparam logic [IDX_W-1:0] IDX_DL_CTRL = 10'h018;
   localparam logic [IDX_W-1:0] IDX_BUF_FIRST = 10'h0de;
   localparam logic [IDX_W-1:0] IDX_BUF_LAST = 10'h135;

   // Receive message buffer
   localparam int BUF_DEPTH = int'(IDX_BUF_LAST) - int'(IDX_BUF_FIRST) + 1;
   localparam int BUF_AW = 7;
   localparam int BYTE_W = 8;

   // Alarm-code processor
   localparam int CODE_W = 6;
   localparam int HIST_LEN = 10;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] VALID_HITS = 4'h8;
   localparam logic [CNT_W-1:0] REMOVE_HITS = 4'h3;

   // Field positions of the alarm-code interrupt control register
   localparam int BIT_VALID_FLAG = 0;
   localparam int BIT_VALID_EN = 1;
   localparam int BIT_REMOVE_FLAG = 2;
   localparam int BIT_REMOVE_EN = 3;
   localparam int BIT_PRESENT = 4;

   // Field positions of the receive data-link control register
   localparam int BIT_MSG_FLAG = 0;
   localparam int BIT_MSG_EN = 1;
   localparam int BIT_DL_EN = 2;

   // Reset values
   localparam logic [CODE_W-1:0] RST_CODE = 6'h00;
   localparam logic RST_EN = 1'b0;
   localparam logic RST_FLAG = 1'b0;

   typedef enum logic [1:0] {
      WR_COLLECT = 2'b00,
      WR_RESPOND = 2'b01
   } rfli_wr_state_type;

   // One alarm-code reception from the receive framer
   typedef struct packed {
      logic strobe;
      logic [CODE_W-1:0] code;
   } rfli_code_rx_type;

   // Message byte writes and completion from the receive HDLC controller
   typedef struct packed {
      logic wr;
      logic [BUF_AW-1:0] addr;
      logic [BYTE_W-1:0] data;
      logic done;
   } rfli_msg_rx_type;

endpackage

// ===== verif/rfli_props.sv
// Purpose: Port-level checks of the alarm-code and data-link event block.
// Assumes: Bound to rfli_top; one clock domain.
// Notes: Shadow enables follow bus writes, so masked events can be told apart.
`timescale 1ns/1ns
module rfli_props
   import rfli_pkg::*;
(
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset, active low
   input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   input wire logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   input wire logic s_axi_wready, // Write data ready
   input wire logic s_axi_bvalid, // Write response valid
   input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   input wire logic s_axi_arready, // Read address ready
   input wire logic [31:0] s_axi_rdata, // Read data
   input wire logic [1:0] s_axi_rresp, // Read response
   input wire logic s_axi_rvalid, // Read data valid
   input wire rfli_code_rx_type code_rx, // Alarm-code receptions
   input wire rfli_msg_rx_type msg_rx, // Message bytes
   input wire logic rx_datalink_en, // Receiver enable
   input wire logic irq_n // Interrupt request
);
   logic [IDX_W-1:0] aw_idx, rd_idx;
   logic [7:0] wd;
   logic ws, bv_q, en_c, en_m;
   wire ar_hs = s_axi_arvalid & s_axi_arready;
   wire ev = code_rx.strobe | msg_rx.done;
   wire wr_end = s_axi_bvalid & ~bv_q;
   always_ff @(posedge aclk) begin
      bv_q <= aresetn & s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) aw_idx <= s_axi_awaddr[ADDR_W-1:2];
      if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[7:0];
      if (s_axi_wvalid && s_axi_wready) ws <= s_axi_wstrb[0];
      if (ar_hs) rd_idx <= s_axi_araddr[ADDR_W-1:2];
      if (!aresetn) en_c <= 1'b0;
      else if (wr_end && ws && aw_idx == IDX_IRQ_CTRL) en_c <= wd[1] | wd[3];
      if (!aresetn) en_m <= 1'b0;
      else if (wr_end && ws && aw_idx == IDX_DL_CTRL) en_m <= wd[1];
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   code_hi_zero_a: assert property (
      s_axi_rvalid && rd_idx == IDX_ALARM_CODE |-> s_axi_rdata[31:6] == 26'h0 &&
      s_axi_rresp == RESP_OKAY) else $error("alarm code read has upper bits set");
   ctrl_hi_zero_a: assert property (
      s_axi_rvalid && rd_idx == IDX_IRQ_CTRL |-> s_axi_rdata[31:5] == 27'h0)
      else $error("irq control read has unused bits set");
   dl_hi_zero_a: assert property (
      s_axi_rvalid && rd_idx == IDX_DL_CTRL |-> s_axi_rdata[31:3] == 29'h0)
      else $error("data-link control read has unused bits set");
   dl_en_follow_a: assert property (
      wr_end && ws && aw_idx == IDX_DL_CTRL |-> rx_datalink_en == wd[2])
      else $error("receiver enable does not follow write");
   irq_masked_a: assert property (
      !en_c && !en_m && !s_axi_bvalid |-> irq_n) else $error("request while all masked");
   irq_fall_cause_a: assert property (
      $fell(irq_n) |-> $past(ev) || $past(ev, 2) || s_axi_bvalid || $past(s_axi_bvalid))
      else $error("request asserted without event");
   irq_rise_cause_a: assert property (
      $rose(irq_n) |-> $past(ar_hs) || $past(ar_hs, 2) || s_axi_bvalid ||
      $past(s_axi_bvalid)) else $error("request released without read or write");
   read_answer_a: assert property (
      ar_hs |=> s_axi_rvalid && !s_axi_arready) else $error("read not answered next cycle");
   irq_seen_c: cover property ($fell(irq_n));
   dl_on_c: cover property ($rose(rx_datalink_en));
   code_read_c: cover property (s_axi_rvalid && rd_idx == IDX_ALARM_CODE);
endmodule
bind rfli_top rfli_props i_rfli_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .code_rx, .msg_rx, .rx_datalink_en, .irq_n);

// ===== verif/rfli_far_end.sv
// Purpose: Receive framer and HDLC controller as seen by the event block.
// Assumes: One-cycle pulses, launched right after a rising edge.
// Notes: Idle payload is inverted so stale values are never trusted.
`timescale 1ns/1ns
module rfli_far_end
   import rfli_pkg::*;
(
   input wire logic aclk, // Clock
   output rfli_code_rx_type code_rx, // Alarm-code receptions
   output rfli_msg_rx_type msg_rx // Message bytes and completion
);
   initial begin
      code_rx = '0;
      msg_rx = '0;
   end
   task automatic send_code(input logic [CODE_W-1:0] c);
      @(posedge aclk);
      code_rx <= '{strobe: 1'b1, code: c};
      @(posedge aclk);
      code_rx <= '{strobe: 1'b0, code: ~c};
   endtask
   task automatic send_byte(input logic [BUF_AW-1:0] a, input logic [BYTE_W-1:0] d);
      @(posedge aclk);
      msg_rx <= '{wr: 1'b1, addr: a, data: d, done: 1'b0};
      @(posedge aclk);
      msg_rx <= '{wr: 1'b0, addr: ~a, data: ~d, done: 1'b0};
   endtask
   task automatic send_done();
      @(posedge aclk);
      msg_rx.done <= 1'b1;
      @(posedge aclk);
      msg_rx.done <= 1'b0;
   endtask
endmodule

// ===== verif/tb_top.sv
// Purpose: Register-level test of alarm-code and data-link events.
// Assumes: bready and rready held high; one lane written.
// Notes: Request level is sampled two edges after the step before each irq check.
`timescale 1ns/1ns
module tb_top;
   import rfli_pkg::*;
   logic aclk = 1'b0;
   logic aresetn;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic rx_datalink_en, irq_n;
   rfli_code_rx_type code_rx;
   rfli_msg_rx_type msg_rx;
   int n_fail = 0;
   int num_checks = 0;
   int k;
   always #5 aclk = ~aclk;
   rfli_top i_rfli_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .code_rx, .msg_rx, .rx_datalink_en, .irq_n);
   rfli_far_end i_rfli_far_end (.aclk, .code_rx, .msg_rx);
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   task automatic irq(input logic e);
      repeat (2) @(posedge aclk);
      chk("irq_n", {31'h0, e}, {31'h0, irq_n});
   endtask
   // Address and data offered together, each released once taken
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
      int i;
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (s_axi_bvalid) break;
         if (s_axi_awready && !ad) s_axi_awvalid <= 1'b0;
         if (s_axi_awready) ad = 1'b1;
         if (s_axi_wready && !wd) s_axi_wvalid <= 1'b0;
         if (s_axi_wready) wd = 1'b1;
      end
      if (i == 40) begin
         n_fail++;
         test_done();
      end
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask
   task automatic rd(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e,
      input logic [1:0] er);
      int i;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (i == 40) begin
         n_fail++;
         test_done();
      end
      chk(nm, e, s_axi_rdata);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask
   initial begin
      aresetn = 1'b0;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'h1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      {s_axi_bready, s_axi_rready} = 2'h3;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("irq_n", 32'h1, {31'h0, irq_n});
      rd("code", 12'h058, 32'h0, RESP_OKAY);
      rd("ctrl", 12'h05c, 32'h0, RESP_OKAY);
      rd("dl", 12'h060, 32'h0, RESP_OKAY);
      rd("gap", 12'h000, 32'h0, RESP_SLVERR);
      wr(12'h058, 8'h3f, RESP_OKAY);
      wr(12'h004, 8'h01, RESP_SLVERR);
      rd("code", 12'h058, 32'h0, RESP_OKAY);
      $display("test reset done");
      wr(12'h05c, 8'h0a, RESP_OKAY);
      for (k = 0; k < 7; k++) i_rfli_far_end.send_code(6'h25);
      irq(1'b1);
      i_rfli_far_end.send_code(6'h25);
      irq(1'b0);
      rd("code", 12'h058, 32'h25, RESP_OKAY);
      rd("ctrl", 12'h05c, 32'h1b, RESP_OKAY);
      irq(1'b1);
      rd("ctrl", 12'h05c, 32'h1a, RESP_OKAY);
      $display("test validation done");
      for (k = 0; k < 2; k++) i_rfli_far_end.send_code(6'h11);
      rd("code", 12'h058, 32'h25, RESP_OKAY);
      i_rfli_far_end.send_code(6'h11);
      irq(1'b0);
      rd("code", 12'h058, 32'h0, RESP_OKAY);
      rd("ctrl", 12'h05c, 32'h0e, RESP_OKAY);
      wr(12'h05c, 8'h00, RESP_OKAY);
      for (k = 0; k < 5; k++) i_rfli_far_end.send_code(6'h11);
      irq(1'b1);
      wr(12'h05c, 8'h02, RESP_OKAY);
      irq(1'b0);
      rd("ctrl", 12'h05c, 32'h13, RESP_OKAY);
      rd("code", 12'h058, 32'h11, RESP_OKAY);
      s_axi_wstrb <= 4'h0;
      wr(12'h05c, 8'h00, RESP_OKAY);
      s_axi_wstrb <= 4'h1;
      rd("ctrl", 12'h05c, 32'h12, RESP_OKAY);
      $display("test removal done");
      wr(12'h060, 8'h04, RESP_OKAY);
      chk("dl_en", 32'h1, {31'h0, rx_datalink_en});
      i_rfli_far_end.send_byte(7'h00, 8'ha5);
      i_rfli_far_end.send_byte(7'h57, 8'h5a);
      i_rfli_far_end.send_done();
      irq(1'b1);
      rd("dl", 12'h060, 32'h05, RESP_OKAY);
      rd("buf_first", 12'h378, 32'ha5, RESP_OKAY);
      rd("buf_last", 12'h4d4, 32'h5a, RESP_OKAY);
      wr(12'h060, 8'h06, RESP_OKAY);
      i_rfli_far_end.send_done();
      irq(1'b0);
      rd("dl", 12'h060, 32'h07, RESP_OKAY);
      irq(1'b1);
      wr(12'h060, 8'h00, RESP_OKAY);
      i_rfli_far_end.send_done();
      rd("dl", 12'h060, 32'h00, RESP_OKAY);
      $display("test message done");
      test_done();
   end
endmodule
